// [rtl/pmm_defs.svh]
// Purpose: register offsets, bit positions and reset values of the power mode manager
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef PMM_DEFS_SVH
`define PMM_DEFS_SVH
`define PMM_CTRL_ADDR     4'h0
`define PMM_STAT_ADDR     4'h4
`define PMM_CLKCTL_ADDR   4'h8
`define PMM_ADDR_W        4
`define PMM_B_PSM         0
`define PMM_B_IDLE        1
`define PMM_B_HALT        2
`define PMM_B_WAITG       3
`define PMM_B_MOFF        4
`define PMM_B_POFF        5
`define PMM_B_LSM         6
`define PMM_B_LSP         7
`define PMM_B_SLOW_RDY    0
`define PMM_B_MAIN_RDY    1
`define PMM_B_PLL_RDY     2
`define PMM_B_PLL_PWD     0
`define PMM_CTRL_RST      8'h00
`define PMM_RESP_OKAY     2'h0
`define PMM_RESP_SLVERR   2'h2
`endif

// [rtl/pmm_pkg.sv]
// Purpose: types shared by the power mode manager
// Assumes: nothing beyond the defs header
// Notes:   mode state codes form a Gray sequence in declaration order
package pmm_pkg;
  typedef enum logic [2:0] {
    PMM_ACTIVE   = 3'h0,
    PMM_PSAVE    = 3'h1,
    PMM_IDLE     = 3'h3,
    PMM_HALT_STP = 3'h2,
    PMM_HALT     = 3'h6,
    PMM_WK_MAIN  = 3'h7,
    PMM_WK_PLL   = 3'h5
  } pmm_state_t;

  typedef struct packed {
    logic main_osc_en;
    logic pll_en;
    logic sys_clk_en;
    logic sys_on_slow;
  } pmm_clk_t;

  typedef struct packed {
    logic slow_osc_ready;
    logic main_osc_ready;
    logic pll_ready;
  } pmm_rdy_t;
endpackage

// [rtl/pmm_power_mode_manager.sv]
// Purpose: four-mode power manager (Active, Power Save, Idle, Halt) with AXI4-Lite registers
// Assumes: aclk is the always-on slow clock; oscillator flags and wake inputs are asynchronous
// Notes:
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "pmm_defs.svh"
module pmm_power_mode_manager
  import pmm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [3:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       cpu_wait,
  input  wire logic       irq_ack,
  input  wire logic       nmi_wake,
  input  wire logic       wakeup_unit_wake,
  input  wire logic       link_sleeping,
  input  wire logic       slow_osc_stable,
  input  wire logic       main_osc_stable,
  input  wire logic       pll_stable,
  output logic            main_osc_en,
  output logic            pll_en,
  output logic            sys_clk_en,
  output logic            sys_on_slow,
  output logic            wake_pending
);
  pmm_state_t  state_q;
  logic [7:0]  ctrl_q;
  logic        pll_pwd_q;
  pmm_clk_t    clk_q;
  pmm_clk_t    clk_d;
  pmm_rdy_t    rdy_q;
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic        wake_q;
  logic        wake_set;
  logic        waitp;
  logic [3:0]  aw_q;
  logic        awh_q;
  logic [7:0]  wd_q;
  logic        wstb_q;
  logic        wh_q;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_clk;
  logic        pll_req;
  logic        imm_req_q;
  logic        exit_req_q;
  logic        wk_pll_q;

  // two-stage synchronisers; only stage two is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {cpu_wait, nmi_wake, wakeup_unit_wake,
                  slow_osc_stable, main_osc_stable, pll_stable};
      sync2_q <= sync1_q;
    end
  end

  assign waitp    = sync2_q[5];
  assign wake_set = sync2_q[4] | sync2_q[3];

  // pll counts as ready when it is not asked for, or once it is stable;
  // the next enable is included so a fresh request is not seen as ready
  assign pll_req = clk_q.pll_en | clk_d.pll_en;

  // status reflects the sources from reset on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_q <= '0;
    end else begin
      rdy_q.slow_osc_ready <= sync2_q[2];
      rdy_q.main_osc_ready <= sync2_q[1] & clk_q.main_osc_en;
      rdy_q.pll_ready      <= ~pll_req | sync2_q[0];
    end
  end

  // registered status lags the pll enable; wake step waits one cycle for it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wk_pll_q <= 1'b0;
    end else begin
      wk_pll_q <= (state_q == PMM_WK_PLL);
    end
  end

  // wake latch: set wins over acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else if (wake_set) begin
      wake_q <= 1'b1;
    end else if (irq_ack) begin
      wake_q <= 1'b0;
    end
  end

  // AXI write channel: address and data taken in either order
  assign wr_go   = awh_q & wh_q & ~s_axi_bvalid;
  assign wr_ctrl = wr_go & wstb_q & (aw_q == `PMM_CTRL_ADDR);
  assign wr_clk  = wr_go & wstb_q & (aw_q == `PMM_CLKCTL_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_q <= 1'b0;
      aw_q  <= 4'h0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      awh_q <= 1'b1;
      aw_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      awh_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wh_q   <= 1'b0;
      wd_q   <= 8'h00;
      wstb_q <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      wh_q   <= 1'b1;
      wd_q   <= s_axi_wdata[7:0];
      wstb_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      wh_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~awh_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~wh_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_q == `PMM_CTRL_ADDR || aw_q == `PMM_CLKCTL_ADDR ||
                       aw_q == `PMM_STAT_ADDR) ? `PMM_RESP_OKAY : `PMM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_pwd_q <= 1'b0;
    end else if (wr_clk) begin
      pll_pwd_q <= wd_q[`PMM_B_PLL_PWD];
    end
  end

  // AXI read channel: one read at a time, answered the cycle after it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PMM_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PMM_RESP_OKAY;
        unique case (s_axi_araddr)
          `PMM_CTRL_ADDR:   s_axi_rdata <= {24'h000000, ctrl_q};
          `PMM_STAT_ADDR:   s_axi_rdata <= {29'h00000000, rdy_q.pll_ready,
                                            rdy_q.main_osc_ready,
                                            rdy_q.slow_osc_ready};
          `PMM_CLKCTL_ADDR: s_axi_rdata <= {31'h00000000, pll_pwd_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMM_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // mode state machine and control register share one process:
  // hardware clears and software writes both land here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= PMM_ACTIVE;
      ctrl_q     <= `PMM_CTRL_RST;
      imm_req_q  <= 1'b0;
      exit_req_q <= 1'b0;
    end else begin
      if (state_q != PMM_PSAVE)
        exit_req_q <= 1'b0;
      if (wr_ctrl) begin
        ctrl_q[`PMM_B_IDLE]  <= wd_q[`PMM_B_IDLE];
        ctrl_q[`PMM_B_HALT]  <= wd_q[`PMM_B_HALT];
        ctrl_q[`PMM_B_WAITG] <= wd_q[`PMM_B_WAITG];
        ctrl_q[`PMM_B_MOFF]  <= wd_q[`PMM_B_MOFF];
        ctrl_q[`PMM_B_POFF]  <= wd_q[`PMM_B_POFF];
        ctrl_q[`PMM_B_LSM]   <= wd_q[`PMM_B_LSM];
        ctrl_q[`PMM_B_LSP]   <= wd_q[`PMM_B_LSP];
        // the written gate bit decides; a write replaces any untaken request
        if (state_q == PMM_ACTIVE) begin
          ctrl_q[`PMM_B_PSM] <= wd_q[`PMM_B_PSM] & wd_q[`PMM_B_WAITG];
          imm_req_q          <= wd_q[`PMM_B_PSM] & ~wd_q[`PMM_B_WAITG];
        end
        if (state_q == PMM_PSAVE)
          exit_req_q <= ~wd_q[`PMM_B_PSM];
      end
      unique case (state_q)
        PMM_ACTIVE: begin
          if (rdy_q.slow_osc_ready) begin
            if (ctrl_q[`PMM_B_WAITG] & waitp) begin
              if (ctrl_q[`PMM_B_HALT])
                state_q <= PMM_HALT_STP;
              else if (ctrl_q[`PMM_B_IDLE])
                state_q <= PMM_IDLE;
              else if (ctrl_q[`PMM_B_PSM])
                state_q <= PMM_PSAVE;
            end else if (imm_req_q) begin
              state_q            <= PMM_PSAVE;
              ctrl_q[`PMM_B_PSM] <= 1'b1;
              imm_req_q          <= 1'b0;
            end
          end
        end
        PMM_PSAVE: begin
          if (wake_q) begin
            state_q <= PMM_WK_MAIN;
          end else if (ctrl_q[`PMM_B_WAITG] & waitp & ctrl_q[`PMM_B_HALT]) begin
            state_q <= PMM_HALT_STP;
          end else if (ctrl_q[`PMM_B_WAITG] & waitp & ctrl_q[`PMM_B_IDLE]) begin
            state_q <= PMM_IDLE;
          end else if (exit_req_q & rdy_q.main_osc_ready &
                       rdy_q.pll_ready) begin
            // bit keeps reading one until active is reached
            state_q            <= PMM_ACTIVE;
            ctrl_q[`PMM_B_PSM] <= 1'b0;
            ctrl_q[`PMM_B_LSM] <= 1'b0;
            ctrl_q[`PMM_B_LSP] <= 1'b0;
          end
        end
        PMM_IDLE: begin
          if (wake_q)
            state_q <= PMM_WK_MAIN;
        end
        PMM_HALT_STP: begin
          // system clock is stopped from this step while oscillators stay on; they go next
          state_q <= PMM_HALT;
        end
        PMM_HALT: begin
          if (wake_q)
            state_q <= PMM_WK_MAIN;
        end
        PMM_WK_MAIN: begin
          ctrl_q[`PMM_B_MOFF] <= 1'b0;
          if (rdy_q.main_osc_ready) begin
            state_q             <= PMM_WK_PLL;
            ctrl_q[`PMM_B_HALT] <= 1'b0;
            ctrl_q[`PMM_B_POFF] <= 1'b0;
          end
        end
        PMM_WK_PLL: begin
          if (wk_pll_q & rdy_q.pll_ready) begin
            state_q <= PMM_ACTIVE;
            ctrl_q[`PMM_B_PSM]  <= 1'b0;
            ctrl_q[`PMM_B_IDLE] <= 1'b0;
            ctrl_q[`PMM_B_HALT] <= 1'b0;
            ctrl_q[`PMM_B_LSM]  <= 1'b0;
            ctrl_q[`PMM_B_LSP]  <= 1'b0;
          end
        end
        default: state_q <= PMM_ACTIVE;
      endcase
    end
  end

  // clock gating follows the mode; in active/halt the off bits do nothing
  always_comb begin
    clk_d = '0;
    unique case (state_q)
      PMM_ACTIVE: begin
        clk_d.main_osc_en = 1'b1;
        clk_d.pll_en      = ~pll_pwd_q;
        clk_d.sys_clk_en  = 1'b1;
      end
      PMM_PSAVE, PMM_IDLE: begin
        clk_d.main_osc_en = ~ctrl_q[`PMM_B_MOFF] &
                            ~(ctrl_q[`PMM_B_LSM] & link_sleeping);
        clk_d.pll_en      = ~ctrl_q[`PMM_B_POFF] & ~pll_pwd_q &
                            ~(ctrl_q[`PMM_B_LSP] & link_sleeping);
        clk_d.sys_clk_en  = (state_q == PMM_PSAVE);
        clk_d.sys_on_slow = 1'b1;
      end
      PMM_HALT_STP: begin
        clk_d.main_osc_en = 1'b1;
        clk_d.pll_en      = ~pll_pwd_q;
      end
      PMM_HALT: begin
        clk_d = '0;
      end
      PMM_WK_MAIN: begin
        clk_d.main_osc_en = 1'b1;
        clk_d.sys_on_slow = 1'b1;
      end
      PMM_WK_PLL: begin
        clk_d.main_osc_en = 1'b1;
        clk_d.pll_en      = ~pll_pwd_q;
        clk_d.sys_on_slow = 1'b1;
      end
      default: clk_d = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q <= '{main_osc_en: 1'b1, pll_en: 1'b1, sys_clk_en: 1'b1, sys_on_slow: 1'b0};
    end else begin
      clk_q <= clk_d;
    end
  end

  assign main_osc_en  = clk_q.main_osc_en;
  assign pll_en       = clk_q.pll_en;
  assign sys_clk_en   = clk_q.sys_clk_en;
  assign sys_on_slow  = clk_q.sys_on_slow;
  assign wake_pending = wake_q;
endmodule

// [sim/pmm_osc_model.sv]
// Purpose: oscillator and pll sources seen by the power manager
// Assumes: a source is stable a fixed count after its enable rises
// Notes:   the slow source is switched by the bench
`timescale 1ns/10ps
module pmm_osc_model #(
  parameter int START_CYC = 8
) (
  input  wire logic aclk,
  input  wire logic slow_ok,
  input  wire logic main_osc_en,
  input  wire logic pll_en,
  output logic      slow_osc_stable,
  output logic      main_osc_stable,
  output logic      pll_stable
);
  int m_cnt = 0;
  int p_cnt = 0;

  // no grace period: stability drops at the first edge after disable, as real parts do
  always @(posedge aclk) begin
    m_cnt <= !main_osc_en ? 0 : (m_cnt < START_CYC ? m_cnt + 1 : m_cnt);
    p_cnt <= !pll_en ? 0 : (p_cnt < START_CYC ? p_cnt + 1 : p_cnt);
  end

  assign slow_osc_stable = slow_ok;
  assign main_osc_stable = (m_cnt == START_CYC);
  assign pll_stable      = (p_cnt == START_CYC);
endmodule

// [sim/pmm_properties.sv]
// Purpose: concurrent checks on the power manager mode and clock outputs
// Assumes: one slow clock domain, synchronous active-low reset
// Notes:   stability inputs are asynchronous, so only past values are trusted
`timescale 1ns/10ps
module pmm_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_ack,
  input wire logic slow_osc_stable,
  input wire logic main_osc_stable,
  input wire logic pll_stable,
  input wire logic main_osc_en,
  input wire logic pll_en,
  input wire logic sys_clk_en,
  input wire logic sys_on_slow,
  input wire logic wake_pending
);
  logic act;
  assign act = sys_clk_en & ~sys_on_slow;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_main_rdy;
    $rose(act) |-> main_osc_en && $past(main_osc_stable);
  endproperty
  a_main_rdy: assert property (p_main_rdy) else $error("active without main ready");
  property p_pll_rdy;
    $rose(act) && pll_en |-> $past(pll_stable);
  endproperty
  a_pll_rdy: assert property (p_pll_rdy) else $error("active with pll unstable");
  property p_slow_rdy;
    $rose(sys_on_slow) || $fell(sys_clk_en) |-> $past(slow_osc_stable);
  endproperty
  a_slow_rdy: assert property (p_slow_rdy) else $error("low mode without slow osc");
  property p_osc_act;
    act |-> main_osc_en;
  endproperty
  a_osc_act: assert property (p_osc_act) else $error("main osc off in active");
  property p_wake_hold;
    wake_pending && !irq_ack |=> wake_pending;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake latch lost");
  property p_ack_clear;
    $fell(wake_pending) |-> $past(irq_ack) || $past(irq_ack, 2);
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("wake cleared without ack");
  property p_wake_ret;
    $rose(wake_pending) |-> ##[0:300] act;
  endproperty
  a_wake_ret: assert property (p_wake_ret) else $error("wake did not reach active");
  property p_wake_order;
    $rose(main_osc_en) && !pll_en |=> !pll_en;
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("pll before main ready");
endmodule

bind pmm_power_mode_manager pmm_props pmm_props_inst (
  .aclk, .aresetn, .irq_ack, .slow_osc_stable, .main_osc_stable, .pll_stable,
  .main_osc_en, .pll_en, .sys_clk_en, .sys_on_slow, .wake_pending
);

// [sim/tb_top.sv]
// Purpose: register-level scenarios for the power mode manager
// Assumes: oscillator model stabilises 8 cycles after enable
// Notes:   waits are bounded; a spent bound counts as a mismatch
`timescale 1ns/10ps
`include "pmm_defs.svh"
module tb_top;
  localparam logic [3:0] CTL = `PMM_CTRL_ADDR;
  localparam logic [3:0] STA = `PMM_STAT_ADDR;
  localparam int MOSC = 0, PLL = 1, SCLK = 2, SLOW = 3, WAKE = 4;
  logic aclk = 1'h0, aresetn = 1'h0, cpu_wait = 1'h0, irq_ack = 1'h0, nmi_wake = 1'h0;
  logic wakeup_unit_wake = 1'h0, link_sleeping = 1'h0, slow_ok = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic slow_osc_stable, main_osc_stable, pll_stable, main_osc_en, pll_en;
  logic sys_clk_en, sys_on_slow, wake_pending;
  logic [4:0] pins;
  int n_mismatch = 0;
  int total_checks = 0;

  assign pins = {wake_pending, sys_on_slow, sys_clk_en, pll_en, main_osc_en};
  always #50 aclk = ~aclk;

  pmm_power_mode_manager pmm_power_mode_manager_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_wait, .irq_ack, .nmi_wake, .wakeup_unit_wake,
    .link_sleeping, .slow_osc_stable, .main_osc_stable, .pll_stable, .main_osc_en,
    .pll_en, .sys_clk_en, .sys_on_slow, .wake_pending
  );
  pmm_osc_model pmm_osc_model_inst (
    .aclk, .slow_ok, .main_osc_en, .pll_en, .slow_osc_stable, .main_osc_stable, .pll_stable
  );

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic hang;
    n_mismatch++;
    $display("unexpected wait limit at %0t: got %0h exp %0h", $time, 0, 1);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic cp(input int i, input logic v);
    chk({31'h0, pins[i]}, {31'h0, v});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 50) hang();
  endtask

  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 50) hang();
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_data & m, e);
  endtask

  task automatic wpin(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pins[i] !== v && n < 500);
    if (n >= 500) hang();
  endtask

  task automatic wake(input logic nmi);
    cpu_wait <= 1'h0;
    @(posedge aclk);
    nmi_wake <= nmi;
    wakeup_unit_wake <= !nmi;
    cyc(4);
    nmi_wake <= 1'h0;
    wakeup_unit_wake <= 1'h0;
  endtask

  task automatic ack;
    cp(WAKE, 1'h1);
    @(posedge aclk);
    irq_ack <= 1'h1;
    @(posedge aclk);
    irq_ack <= 1'h0;
    cyc(3);
    cp(WAKE, 1'h0);
  endtask

  initial begin
    cyc(10);
    aresetn <= 1'h1;
    cyc(14);
    rdchk(CTL, 32'hFFFFFFFF, 32'h0);
    rdchk(STA, 32'hFFFFFFFF, 32'h7);
    rd(4'hC);
    chk({30'h0, rsp}, {30'h0, `PMM_RESP_SLVERR});
    wr(4'hC, 32'h0);
    chk({30'h0, rsp}, {30'h0, `PMM_RESP_SLVERR});
    // slow source gone: immediate save must stall until it returns
    slow_ok <= 1'h0;
    cyc(5);
    wr(CTL, 32'h1);
    chk({30'h0, rsp}, {30'h0, `PMM_RESP_OKAY});
    cyc(20);
    cp(SLOW, 1'h0);
    rdchk(CTL, 32'hFF, 32'h0);
    slow_ok <= 1'h1;
    wpin(SLOW, 1'h1);
    cp(SCLK, 1'h1);
    rdchk(CTL, 32'hFF, 32'h1);
    wr(CTL, 32'h11);
    wpin(MOSC, 1'h0);
    wr(CTL, 32'h1);
    wpin(MOSC, 1'h1);
    cyc(16);
    rdchk(STA, 32'h2, 32'h2);
    wr(CTL, 32'h0);
    wpin(SLOW, 1'h0);
    rdchk(CTL, 32'hFF, 32'h0);
    wr(CTL, 32'h39);
    rdchk(CTL, 32'hFF, 32'h39);
    cyc(10);
    cp(SLOW, 1'h0);
    cp(MOSC, 1'h1);
    cp(PLL, 1'h1);
    cpu_wait <= 1'h1;
    wpin(SLOW, 1'h1);
    wpin(MOSC, 1'h0);
    wpin(PLL, 1'h0);
    wake(1'h1);
    wpin(MOSC, 1'h1);
    cp(PLL, 1'h0);
    wpin(SLOW, 1'h0);
    cp(PLL, 1'h1);
    rdchk(CTL, 32'h31, 32'h0);
    ack();
    link_sleeping <= 1'h1;
    wr(CTL, 32'hCA);
    cp(MOSC, 1'h1);
    cpu_wait <= 1'h1;
    wpin(SCLK, 1'h0);
    wpin(MOSC, 1'h0);
    wpin(PLL, 1'h0);
    wake(1'h0);
    wpin(SCLK, 1'h1);
    rdchk(CTL, 32'hC2, 32'h0);
    link_sleeping <= 1'h0;
    ack();
    wr(CTL, 32'h0C);
    cpu_wait <= 1'h1;
    wpin(SCLK, 1'h0);
    cp(MOSC, 1'h1);
    wpin(MOSC, 1'h0);
    cp(PLL, 1'h0);
    cyc(20);
    cp(MOSC, 1'h0);
    wake(1'h0);
    rdchk(CTL, 32'h4, 32'h4);
    wpin(SCLK, 1'h1);
    rdchk(CTL, 32'h4, 32'h0);
    ack();
    wr(`PMM_CLKCTL_ADDR, 32'h1);
    wpin(PLL, 1'h0);
    cp(MOSC, 1'h1);
    rdchk(STA, 32'h4, 32'h4);
    wr(`PMM_CLKCTL_ADDR, 32'h0);
    wpin(PLL, 1'h1);
    give_verdict();
  end
endmodule
